// ==== design/dsr_pkg.sv ====
// constants and types shared by the debug status register logic
package dsr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map, reached by the debug register read and write commands
    localparam logic [17:0] DSR_ADDR_STATUS = 18'h3FF01; // debug_status
    localparam logic [17:0] DSR_ADDR_SAVED  = 18'h3FF06; // saved flags

    ////////////////////////////////////////////////////////////////////////
    // field positions inside debug_status
    localparam int DSR_BIT_ENABLE = 7; // debug_enable_flag
    localparam int DSR_BIT_ACTIVE = 6; // debug_active_flag
    localparam int DSR_BIT_SHIFT  = 4; // shift_done_flag
    localparam int DSR_BIT_STEP   = 3; // single step executing
    localparam int DSR_BIT_UNLOCK = 1; // unlocked_flag

    // implemented bits; bits 5, 2 and 0 are not among them
    localparam logic [7:0] DSR_STATUS_MASK = 8'hDA;

    ////////////////////////////////////////////////////////////////////////
    // reset and load values
    localparam logic [7:0] DSR_SAVED_SPECIAL = 8'hD8; // special single chip
    localparam logic [7:0] DSR_SAVED_OTHER   = 8'h00; // all other modes
    localparam logic [7:0] DSR_BYTE_ZERO     = 8'h00; // refused or unmapped

    ////////////////////////////////////////////////////////////////////////
    // timing: last settle count; the strap gets four cycles, the synchroniser needs two
    localparam logic [1:0] DSR_SETTLE_CYCLES = 2'h3;
    localparam logic [1:0] DSR_SETTLE_ONE    = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // who issues a register access
    typedef enum logic [1:0] {
        DSR_SRC_HW_CMD = 2'b00, // hardware command from the host
        DSR_SRC_STD_FW = 2'b01, // standard debug firmware
        DSR_SRC_SEC_FW = 2'b10, // secure debug firmware
        DSR_SRC_NONE   = 2'b11  // no source, writes ignored
    } dsr_src_t;

    // start-up sequence
    typedef enum logic [1:0] {
        DSR_ST_SETTLE = 2'b00, // let the strap pass the synchroniser
        DSR_ST_INIT   = 2'b01, // load mode dependent values
        DSR_ST_ERASE  = 2'b10, // secured: wait for erase verify
        DSR_ST_RUN    = 2'b11  // normal operation
    } dsr_state_t;

endpackage : dsr_pkg

// ==== design/dsr_status_regs.sv ====
// debug status register, saved flags register and their hardware updates
`timescale 1ns/100ps
`default_nettype none

module dsr_status_regs
    import dsr_pkg::*;
(
    input  wire logic       clk_in,              // 25 MHz system clock
    input  wire logic       rst_n_in,            // async reset, active low
    input  wire logic       mode_pin_in,         // strap: 1 special mode
    input  wire logic       secured_in,          // part is secured
    input  wire logic       sec_byte_unlocked_flag_in,   // security byte unsecure
    input  wire logic       erase_done_in,       // erase verify finished
    input  wire logic       flash_erased_in,     // erase verify passed
    input  wire logic       reg_wr_in,           // register write strobe
    input  wire logic       reg_rd_in,           // register read strobe
    input  wire logic [17:0] reg_addr_in,        // global register address
    input  wire logic [7:0] reg_wdata_in,        // write data
    input  wire logic [1:0] reg_src_in,          // access source
    input  wire logic       exit_seq_in,         // firmware exit sequence
    input  wire logic       entry_req_in,        // request to enter debug
    input  wire logic [7:0] cpu_flags_in,        // cpu condition code
    input  wire logic       cmd_received_in,     // next command received
    input  wire logic       data_shifted_in,     // data phase finished
    input  wire logic       step_cmd_in,         // single step recognised
    input  wire logic       resume_cmd_in,       // resume or resume-until
    output var  logic [7:0] reg_rdata_out,       // read data
    output var  logic       reg_ack_out,         // access answered pulse
    output var  logic       debug_enable_out,    // debug_enable_flag
    output var  logic       debug_active_out,    // debug_active_flag
    output var  logic       shift_done_out,      // shift_done_flag
    output var  logic       single_step_out,     // single step executing
    output var  logic       unlocked_out,        // unlocked_flag
    output var  logic [7:0] saved_flags_out,     // saved_flags_register
    output var  logic       std_table_out,       // standard table mapped
    output var  logic       sec_table_out,       // secure table mapped
    output var  logic       fw_cmds_ok_out,      // firmware cmds allowed
    output var  logic       security_off_out,    // part acts unsecured
    output var  logic       entry_refused_out,   // entry ignored pulse
    output var  logic       special_mode_out,    // captured mode
    output var  logic       ready_out            // start-up finished
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // register access is open when the part is not secured or is unlocked
    function automatic logic access_ok(input logic secured,
                                       input logic unlocked);
        access_ok = !secured || unlocked;
    endfunction : access_ok

    // pack the status byte; unused bits always zero
    function automatic logic [7:0] pack_status(input logic en,
                                               input logic act,
                                               input logic sd,
                                               input logic st,
                                               input logic un);
        logic [7:0] b;
        b = DSR_BYTE_ZERO;
        b[DSR_BIT_ENABLE] = en;
        b[DSR_BIT_ACTIVE] = act;
        b[DSR_BIT_SHIFT]  = sd;
        b[DSR_BIT_STEP]   = st;
        b[DSR_BIT_UNLOCK] = un;
        pack_status = b & DSR_STATUS_MASK;
    endfunction : pack_status

    ////////////////////////////////////////////////////////////////////////
    // mode strap synchroniser
    logic mode_sync; // strap level in the clock domain

    dsr_sync u_mode_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .level_in  (mode_pin_in),
        .level_out (mode_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // state
    dsr_state_t state;         // start-up sequence
    dsr_state_t next_state;    // next sequence state
    logic [1:0] settle;        // strap settle count
    logic [1:0] next_settle;
    logic       next_special;
    logic       next_enable;
    logic       next_active;
    logic       next_shift;
    logic       next_step;
    logic       next_unlocked;
    logic       next_sec_table;
    logic [7:0] next_saved;
    logic       next_std_table;
    logic       next_fw_ok;
    logic       next_sec_off;
    logic       next_refused;
    logic       next_ack;
    logic [7:0] next_rdata;
    logic       next_ready;

    // decoded access, from the current flag values
    dsr_src_t   src;           // access source
    logic       open_now;      // access allowed this cycle
    logic       hit_status;    // address is debug_status
    logic       hit_saved;     // address is saved flags
    logic       sec_fw_write;  // secure firmware may write unlocked
    logic       exit_store;    // firmware store clearing active

    always_comb begin
        src          = dsr_src_t'(reg_src_in);
        open_now     = access_ok(secured_in, unlocked_out);
        hit_status   = (reg_addr_in == DSR_ADDR_STATUS);
        hit_saved    = (reg_addr_in == DSR_ADDR_SAVED);
        sec_fw_write = secured_in && special_mode_out
                       && (src == DSR_SRC_SEC_FW);
        // only the standard firmware in its exit sequence may clear it
        exit_store   = reg_wr_in && hit_status && open_now
                       && (src == DSR_SRC_STD_FW) && exit_seq_in
                       && !reg_wdata_in[DSR_BIT_ACTIVE];
    end

    ////////////////////////////////////////////////////////////////////////
    // next values of every flag and of the bus answer
    always_comb begin
        next_state     = state;
        next_settle    = settle;
        next_special   = special_mode_out;
        next_enable    = debug_enable_out;
        next_active    = debug_active_out;
        next_shift     = shift_done_out;
        next_step      = single_step_out;
        next_unlocked  = unlocked_out;
        next_sec_table = sec_table_out;
        next_saved     = saved_flags_out;
        next_rdata     = reg_rdata_out;
        next_refused   = 1'b0;
        next_ack       = 1'b0;
        next_ready     = ready_out;

        unique case (state)
            // strap needs two clocks through the synchroniser
            DSR_ST_SETTLE: begin
                if (settle == DSR_SETTLE_CYCLES) begin
                    next_state = DSR_ST_INIT;
                end else begin
                    next_settle = settle + DSR_SETTLE_ONE;
                end
            end
            // mode dependent values, loaded after release, never at reset
            DSR_ST_INIT: begin
                next_special = mode_sync;
                if (mode_sync) begin
                    next_active = 1'b1;
                    next_saved  = DSR_SAVED_SPECIAL;
                    if (secured_in) begin
                        next_sec_table = 1'b1;
                        next_unlocked  = 1'b0;
                        next_state     = DSR_ST_ERASE;
                    end else begin
                        next_enable = 1'b1;
                        next_ready  = 1'b1;
                        next_state  = DSR_ST_RUN;
                    end
                end else begin
                    next_saved = DSR_SAVED_OTHER;
                    next_ready = 1'b1;
                    next_state = DSR_ST_RUN;
                end
            end
            // enable waits for the erase verify to finish
            DSR_ST_ERASE: begin
                if (erase_done_in) begin
                    next_enable = 1'b1;
                    if (flash_erased_in) begin
                        next_unlocked  = 1'b1;
                        next_sec_table = 1'b0;
                    end
                    next_ready = 1'b1;
                    next_state = DSR_ST_RUN;
                end
            end
            DSR_ST_RUN: begin
                next_state = DSR_ST_RUN;
            end
        endcase

        // register writes, only once start-up values are in place
        if (state[1] && reg_wr_in) begin
            next_ack = 1'b1;
            if (hit_status && open_now && (src != DSR_SRC_NONE)) begin
                next_enable = reg_wdata_in[DSR_BIT_ENABLE];
                next_shift  = reg_wdata_in[DSR_BIT_SHIFT];
                next_step   = reg_wdata_in[DSR_BIT_STEP];
            end
            if (hit_status && secured_in) begin
                // while secured the flag belongs to the secure firmware
                if (sec_fw_write) begin
                    next_unlocked = reg_wdata_in[DSR_BIT_UNLOCK];
                    if (reg_wdata_in[DSR_BIT_UNLOCK]) begin
                        next_sec_table = 1'b0;
                    end
                end
            end else if (hit_status && (src != DSR_SRC_NONE)) begin
                next_unlocked = reg_wdata_in[DSR_BIT_UNLOCK];
            end
            if (hit_saved && open_now && (src != DSR_SRC_NONE)) begin
                next_saved = reg_wdata_in;
            end
        end

        // exit from debug: memory leaves the map, data phase forgotten
        if (state[1] && exit_store) begin
            next_active = 1'b0;
            next_shift  = 1'b0;
        end

        // hardware events after writes, so they beat writes; among events a set beats a clear
        if (state[1]) begin
            if (cmd_received_in) begin
                next_shift = 1'b0;
            end
            if (data_shifted_in) begin
                next_shift = 1'b1;
            end
            if (resume_cmd_in) begin
                next_step = 1'b0;
            end
            if (step_cmd_in && debug_active_out) begin
                next_step = 1'b1;
            end
            // entry is refused while disabled, not merely delayed
            if (entry_req_in) begin
                if (!debug_enable_out) begin
                    next_refused = 1'b1;
                end else if (!debug_active_out) begin
                    next_active = 1'b1;
                    next_saved  = cpu_flags_in;
                end
            end
        end

        // reads: refused while secured and not unlocked, unmapped addresses read zero
        if (state[1] && reg_rd_in) begin
            next_ack = 1'b1;
            if (!open_now) begin
                next_rdata = DSR_BYTE_ZERO;
            end else if (hit_status) begin
                next_rdata = pack_status(debug_enable_out,
                                         debug_active_out,
                                         shift_done_out,
                                         single_step_out,
                                         unlocked_out);
            end else if (hit_saved) begin
                next_rdata = saved_flags_out;
            end else begin
                next_rdata = DSR_BYTE_ZERO;
            end
        end

        // map and permission outputs follow the new flag values
        next_std_table = next_active && !next_sec_table;
        next_fw_ok     = next_std_table
                         && access_ok(secured_in, next_unlocked);
        // with an unsecure security byte the flag changes nothing
        next_sec_off   = sec_byte_unlocked_flag_in || next_unlocked;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; reset takes constants, mode values load in init
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state             <= DSR_ST_SETTLE;
            settle            <= 2'h0;
            special_mode_out  <= 1'b0;
            debug_enable_out  <= 1'b0;
            debug_active_out  <= 1'b0;
            shift_done_out    <= 1'b0;
            single_step_out   <= 1'b0;
            unlocked_out      <= 1'b0;
            sec_table_out     <= 1'b0;
            saved_flags_out   <= DSR_SAVED_OTHER;
            std_table_out     <= 1'b0;
            fw_cmds_ok_out    <= 1'b0;
            security_off_out  <= 1'b0;
            entry_refused_out <= 1'b0;
            reg_ack_out       <= 1'b0;
            reg_rdata_out     <= DSR_BYTE_ZERO;
            ready_out         <= 1'b0;
        end else begin
            state             <= next_state;
            settle            <= next_settle;
            special_mode_out  <= next_special;
            debug_enable_out  <= next_enable;
            debug_active_out  <= next_active;
            shift_done_out    <= next_shift;
            single_step_out   <= next_step;
            unlocked_out      <= next_unlocked;
            sec_table_out     <= next_sec_table;
            saved_flags_out   <= next_saved;
            std_table_out     <= next_std_table;
            fw_cmds_ok_out    <= next_fw_ok;
            security_off_out  <= next_sec_off;
            entry_refused_out <= next_refused;
            reg_ack_out       <= next_ack;
            reg_rdata_out     <= next_rdata;
            ready_out         <= next_ready;
        end
    end

endmodule : dsr_status_regs

`default_nettype wire

// ==== design/dsr_sync.sv ====
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none

module dsr_sync (
    input  wire logic clk_in,    // system clock
    input  wire logic rst_n_in,  // async reset, active low
    input  wire logic level_in,  // asynchronous level
    output var  logic level_out  // level in the clock domain
);

    ////////////////////////////////////////////////////////////////////////
    logic meta;       // first stage, read only by the second
    logic next_meta;  // next first stage
    logic next_level; // next second stage

    // first stage feeds only the second stage
    always_comb begin
        next_meta  = level_in;
        next_level = meta;
    end

    // both stages clear on reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta      <= 1'b0;
            level_out <= 1'b0;
        end else begin
            meta      <= next_meta;
            level_out <= next_level;
        end
    end

endmodule : dsr_sync

`default_nettype wire

// ==== sim/dsr_host_model.sv ====
// host side model: debug register read and write commands
`timescale 1ns/100ps
`default_nettype none

module dsr_host (
    input  wire logic        clk_in,    // system clock
    input  wire logic        ack_in,    // access answered
    input  wire logic [7:0]  rdata_in,  // read data
    output var  logic        wr_out,    // write strobe
    output var  logic        rd_out,    // read strobe
    output var  logic [17:0] addr_out,  // register address
    output var  logic [7:0]  wdata_out, // write data
    output var  logic [1:0]  src_out,   // access source
    output var  logic        exit_out   // exit store qualifier
);
    // idle levels before the first access
    initial begin
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        addr_out  = 18'h00000;
        wdata_out = 8'h00;
        src_out   = 2'b00;
        exit_out  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one access: strobe is a one cycle pulse, answer waited a few cycles
    task automatic access(input logic w, input logic [17:0] a,
                          input logic [7:0] d, input logic [1:0] s,
                          input logic x, output logic [7:0] q);
        int n;
        @(posedge clk_in) #1;
        wr_out    = w;
        rd_out    = !w;
        addr_out  = a;
        wdata_out = d;
        src_out   = s;
        exit_out  = x;
        @(posedge clk_in) #1;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        // released data lines never keep the last value
        wdata_out = ~d;
        exit_out  = 1'b0;
        n = 0;
        while (ack_in !== 1'b1 && n < 4) begin
            @(posedge clk_in) #1;
            n++;
        end
        q = rdata_in;
    endtask : access
endmodule : dsr_host

`default_nettype wire

// ==== sim/dsr_status_regs_sva.sv ====
// assertion checker for the debug status register ports
`timescale 1ns/100ps
`default_nettype none

module dsr_chk
    import dsr_pkg::*;
(
    input wire logic        clk_in,            // system clock
    input wire logic        rst_n_in,          // async reset
    input wire logic        secured_in,        // part secured
    input wire logic        reg_wr_in,         // write strobe
    input wire logic        reg_rd_in,         // read strobe
    input wire logic [17:0] reg_addr_in,       // address
    input wire logic [1:0]  reg_src_in,        // source
    input wire logic        exit_seq_in,       // exit qualifier
    input wire logic        entry_req_in,      // entry request
    input wire logic [7:0]  cpu_flags_in,      // cpu flags
    input wire logic        cmd_received_in,   // command received
    input wire logic        data_shifted_in,   // data phase done
    input wire logic        step_cmd_in,       // single step
    input wire logic        resume_cmd_in,     // resume
    input wire logic [7:0]  reg_rdata_out,     // read data
    input wire logic        reg_ack_out,       // answer pulse
    input wire logic        debug_enable_out,  // enable flag
    input wire logic        debug_active_out,  // active flag
    input wire logic        shift_done_out,    // shift done
    input wire logic        single_step_out,   // step flag
    input wire logic        unlocked_out,      // unlocked flag
    input wire logic [7:0]  saved_flags_out,   // saved flags
    input wire logic        entry_refused_out, // refused pulse
    input wire logic        ready_out          // start-up done
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic exit_q; // exit store taken at last edge
    logic srd_q;  // status read taken at last edge

    // registered causes, so no expression sits inside a past value
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            exit_q <= 1'b0;
            srd_q  <= 1'b0;
        end else begin
            exit_q <= reg_wr_in && exit_seq_in && reg_src_in == 2'b01;
            srd_q  <= reg_rd_in && reg_addr_in == DSR_ADDR_STATUS;
        end
    end

    sequence s_entry_ok;
        entry_req_in && debug_enable_out && !debug_active_out && ready_out;
    endsequence
    sequence s_step_hold;
        single_step_out && !resume_cmd_in && !reg_wr_in;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_ack_one: assert property ((reg_wr_in || reg_rd_in) && ready_out
        |=> reg_ack_out ##1 !reg_ack_out) else $error("no single ack");
    a_unused_zero: assert property (reg_ack_out && srd_q
        |-> (reg_rdata_out & ~DSR_STATUS_MASK) == 8'h00)
        else $error("unused status bits set");
    a_entry_sets: assert property (s_entry_ok |=> debug_active_out
        && saved_flags_out == $past(cpu_flags_in)) else $error("bad entry");
    a_active_clear: assert property ($fell(debug_active_out)
        |-> exit_q) else $error("active cleared without exit store");
    a_shift_set: assert property (data_shifted_in && ready_out
        |=> shift_done_out) else $error("shift done not set");
    a_shift_clear: assert property (cmd_received_in && !data_shifted_in
        && !reg_wr_in && ready_out |=> !shift_done_out)
        else $error("shift done not cleared");
    a_step_set: assert property (step_cmd_in && debug_active_out
        && ready_out |=> single_step_out) else $error("step not set");
    a_step_hold: assert property (s_step_hold |=> single_step_out)
        else $error("step dropped early");
    a_entry_refused: assert property (entry_req_in && !debug_enable_out
        && ready_out |=> entry_refused_out) else $error("entry not refused");
    a_secured_read: assert property (reg_rd_in && secured_in
        && !unlocked_out && ready_out |=> reg_rdata_out == 8'h00)
        else $error("secured read leaked data");
endmodule : dsr_chk

bind dsr_status_regs dsr_chk chk_u (.*);

`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking testbench for the debug status register logic
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end

module testbench
    import dsr_pkg::*;
;
    logic clk_in, rst_n_in, mode, sec, sbu, ed, fe, ent, cmd, dsh, stp, res;
    logic wr, rd, ack, exq, en, act, sd, st, un, stdt, sect, fwok, soff, refd;
    logic        spm, rdy;
    logic [17:0] addr;
    logic [7:0]  wd, cf, rdat, saved, rq, d;
    logic [1:0]  src;
    int          bad_count, comparisons;

    dsr_status_regs dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .mode_pin_in(mode), .secured_in(sec), .sec_byte_unlocked_flag_in(sbu),
        .erase_done_in(ed), .flash_erased_in(fe), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_src_in(src), .exit_seq_in(exq), .entry_req_in(ent),
        .cpu_flags_in(cf), .cmd_received_in(cmd), .data_shifted_in(dsh),
        .step_cmd_in(stp), .resume_cmd_in(res), .reg_rdata_out(rdat),
        .reg_ack_out(ack), .debug_enable_out(en), .debug_active_out(act),
        .shift_done_out(sd), .single_step_out(st), .unlocked_out(un),
        .saved_flags_out(saved), .std_table_out(stdt), .sec_table_out(sect),
        .fw_cmds_ok_out(fwok), .security_off_out(soff),
        .entry_refused_out(refd), .special_mode_out(spm), .ready_out(rdy));
    dsr_host host_u (.clk_in(clk_in), .ack_in(ack), .rdata_in(rdat),
        .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wd),
        .src_out(src), .exit_out(exq));

    // 25 MHz system clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // expected status after a plain write while not active or secured
    function automatic logic [7:0] st_exp(input logic [7:0] v);
        return v & DSR_STATUS_MASK & 8'hBF;
    endfunction : st_exp

    task automatic wrs(input logic [7:0] v, input logic [1:0] s,
                       input logic x);
        host_u.access(1'b1, DSR_ADDR_STATUS, v, s, x, rq);
    endtask : wrs
    task automatic rdr(input logic [17:0] a);
        host_u.access(1'b0, a, 8'h00, 2'b00, 1'b0, rq);
    endtask : rdr
    // one cycle event pulse: entry, command, data, step, resume
    task automatic ev(input logic [4:0] m);
        {ent, cmd, dsh, stp, res} = m;
        @(posedge clk_in) #1;
        {ent, cmd, dsh, stp, res} = 5'h00;
    endtask : ev
    task automatic rst(input logic m, input logic s);
        rst_n_in = 1'b0;
        mode = m;
        sec = s;
        repeat (6) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        repeat (7) @(posedge clk_in);
        #1;
    endtask : rst
    task automatic erase(input logic e);
        ed = 1'b1;
        fe = e;
        repeat (2) @(posedge clk_in) #1;
        ed = 1'b0;
    endtask : erase

    task automatic test_done;
        $display("checks %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #200000;
        bad_count++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {sbu, ed, fe, ent, cmd, dsh, stp, res} = 8'h00;
        cf = 8'h00;
        bad_count = 0;
        comparisons = 0;
        void'($urandom(85387));
        rst(1'b0, 1'b0);
        `CHK({spm, rdy}, 2'b01)
        rdr(DSR_ADDR_SAVED);
        `CHK(rq, DSR_SAVED_OTHER)
        ev(5'b10000);
        `CHK({refd, act}, 2'b10)
        sbu = 1'b1;
        repeat (2) @(posedge clk_in) #1;
        `CHK(soff, 1'b1)
        sbu = 1'b0;
        $display("normal reset test done");
        // random writes by the host, each read back at once
        for (int i = 0; i < 24; i++) begin
            d = 8'($urandom);
            wrs(d, 2'b00, 1'b0);
            rdr(DSR_ADDR_STATUS);
            `CHK(rq, st_exp(d))
            host_u.access(1'b1, DSR_ADDR_SAVED, ~d, 2'b00, 1'b0, rq);
            rdr(DSR_ADDR_SAVED);
            `CHK(rq, ~d)
        end
        wrs(8'h80, 2'b00, 1'b0);
        $display("random write test done");
        cf = 8'($urandom);
        ev(5'b10000);
        `CHK({act, stdt}, 2'b11)
        `CHK(saved, cf)
        ev(5'b00100);
        `CHK(sd, 1'b1)
        ev(5'b01000);
        `CHK(sd, 1'b0)
        ev(5'b00010);
        ev(5'b01000);
        `CHK(st, 1'b1)
        ev(5'b00001);
        `CHK(st, 1'b0)
        wrs(8'h80, 2'b00, 1'b0);
        `CHK(act, 1'b1)
        ev(5'b00100);
        wrs(8'h80, 2'b01, 1'b1);
        `CHK({act, sd}, 2'b00)
        $display("entry and exit test done");
        rst(1'b1, 1'b0);
        `CHK({en, act, saved}, {2'b11, DSR_SAVED_SPECIAL})
        rdr(DSR_ADDR_STATUS);
        `CHK(rq, 8'hC0)
        $display("special open test done");
        rst(1'b1, 1'b1);
        `CHK({en, act, sect, un}, 4'b0110)
        `CHK({spm, rdy}, 2'b10)
        wrs(8'h02, 2'b00, 1'b0);
        `CHK(un, 1'b0)
        erase(1'b0);
        `CHK({en, un, fwok}, 3'b100)
        rdr(DSR_ADDR_STATUS);
        `CHK(rq, 8'h00)
        rst(1'b1, 1'b1);
        erase(1'b1);
        `CHK({en, un, sect, soff}, 4'b1101)
        rdr(DSR_ADDR_STATUS);
        `CHK(rq, 8'hC2)
        // secure firmware unlocks while still waiting for erase verify
        rst(1'b1, 1'b1);
        wrs(8'h02, 2'b10, 1'b0);
        `CHK({un, sect, fwok}, 3'b101)
        // an access with no source changes nothing
        wrs(8'h80, 2'b11, 1'b0);
        `CHK({en, un}, 2'b01)
        $display("special secured test done");
        test_done;
    end
endmodule : testbench

`default_nettype wire
